// ===== rtl/ssmt_top.sv
// synchronous serial master transmitter with an ahb-lite register slave
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - synchronous select set gives clocked operation, not async framing
// - clock source master set makes the port generate the shift clock; the code toggles it only in transmit, receive holds it at the idle level
// - both receive enables clear means transmit, either set means receive
// - nothing operates unless the serial port enable is set
// - no start or stop bit, only data bits are shifted
// - data line is half duplex, never driven while receiving
// - clock pin driver on whenever sync transmit or receive configured; driven only when clock source master is also set
// - exactly one clock per data bit, none beyond the character
// - data changes on leading edge, stable at trailing edge
// - polarity set: idle high, data changes on falling edge
// - polarity clear: idle low, data changes on rising edge
// - master transmit drives data and clock pin drivers on
// - holding write starts sending, waits while shifter still busy
// - empty shifter takes holding data at once and starts shifting
// - each bit holds from one leading edge to the next
// - shift register is not visible to software
// - unimplemented register bits read as zero
// - shift register empty shows whether a transmit is active
// - buffer empty flag sets when the holding register empties
module ssmt_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [ssmt_pkg::DATA_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [ssmt_pkg::DATA_W-1:0] hwdata,
   input wire logic hready,
   output logic [ssmt_pkg::DATA_W-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic dataIn,
   output logic dataOut,
   output logic dataOe,
   output logic clkPinOut,
   output logic clkPinOe
);
   import ssmt_pkg::*;

   logic addrOk, wrPhase, rdPhase;
   logic [DATA_W-1:0] phaseAddr, readValue;
   logic pol, wide, serial_port_enable, rx9, single_receive_enable, continuous_receive_enable, adden, clock_source_master, tx9, transmit_enable, syncSel;
   logic sendBreak, highSpeed, ninth_tx_bit;
   logic [BYTE_W-1:0] divLo, divHi, holdData;
   logic holdFull, wrHold, txMode, clkMode, busy, halfTick, leadTick;
   logic trailTick, charDone, load, nextActive, dinMeta, dinSync;
   ssmt_state_t state;
   logic [CHAR_W-1:0] shiftReg;
   logic [LEN_W-1:0] bitsLeft, charLen, leadCount, loadLen;
   logic [BAUD_W:0] leadWait;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // bus address phase capture
   assign addrOk = hsel && htrans[1] && hready;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPhase <= 1'b0;
         rdPhase <= 1'b0;
         phaseAddr <= RST_WORD;
      end else begin
         wrPhase <= addrOk && hwrite;
         rdPhase <= addrOk && !hwrite;
         if (addrOk) begin
            phaseAddr <= haddr;
         end
      end
   end

   // reads take one wait state, writes none
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= RST_WORD;
      end else begin
         hreadyout <= !(addrOk && !hwrite);
         hresp <= 1'b0;
         if (rdPhase) begin
            hrdata <= readValue;
         end
      end
   end

   // read mux; unmapped and unused bits give zero
   always_comb begin
      readValue = RST_WORD;
      case (phaseAddr)
         OFF_BAUD_CTL: begin
            readValue[BC_POL] = pol;
            readValue[BC_WIDE] = wide;
         end
         OFF_RX_CTL: begin
            readValue[RC_SERIAL_PORT_ENABLE] = serial_port_enable;
            readValue[RC_RX9] = rx9;
            readValue[RC_SINGLE_RECEIVE_ENABLE] = single_receive_enable;
            readValue[RC_CONTINUOUS_RECEIVE_ENABLE] = continuous_receive_enable;
            readValue[RC_ADDEN] = adden;
         end
         OFF_DIV_LO: readValue[BYTE_W-1:0] = divLo;
         OFF_DIV_HI: readValue[BYTE_W-1:0] = divHi;
         OFF_TX_CTL: begin
            readValue[TC_CLOCK_SOURCE_MASTER] = clock_source_master;
            readValue[TC_TX9] = tx9;
            readValue[TC_TRANSMIT_ENABLE] = transmit_enable;
            readValue[TC_SYNC] = syncSel;
            readValue[TC_BRK] = sendBreak;
            readValue[TC_HSPD] = highSpeed;
            readValue[TC_SHIFT_REGISTER_EMPTY] = !busy;
            readValue[TC_NINTH_TX_BIT] = ninth_tx_bit;
         end
         OFF_LINE_STAT: begin
            readValue[LS_TXEMPTY] = !holdFull;
            readValue[LS_DLINE] = dinSync;
         end
         default: readValue = RST_WORD;
      endcase
   end

   // configuration registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pol <= 1'b0;
         wide <= 1'b0;
         divLo <= RST_BYTE;
         divHi <= RST_BYTE;
      end else if (wrPhase) begin
         if (phaseAddr == OFF_BAUD_CTL) begin
            pol <= hwdata[BC_POL];
            wide <= hwdata[BC_WIDE];
         end
         if (phaseAddr == OFF_DIV_LO) begin
            divLo <= hwdata[BYTE_W-1:0];
         end
         if (phaseAddr == OFF_DIV_HI) begin
            divHi <= hwdata[BYTE_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serial_port_enable <= 1'b0;
         rx9 <= 1'b0;
         single_receive_enable <= 1'b0;
         continuous_receive_enable <= 1'b0;
         adden <= 1'b0;
      end else if (wrPhase && phaseAddr == OFF_RX_CTL) begin
         serial_port_enable <= hwdata[RC_SERIAL_PORT_ENABLE];
         rx9 <= hwdata[RC_RX9];
         single_receive_enable <= hwdata[RC_SINGLE_RECEIVE_ENABLE];
         continuous_receive_enable <= hwdata[RC_CONTINUOUS_RECEIVE_ENABLE];
         adden <= hwdata[RC_ADDEN];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clock_source_master <= 1'b0;
         tx9 <= 1'b0;
         transmit_enable <= 1'b0;
         syncSel <= 1'b0;
         sendBreak <= 1'b0;
         highSpeed <= 1'b0;
         ninth_tx_bit <= 1'b0;
      end else if (wrPhase && phaseAddr == OFF_TX_CTL) begin
         clock_source_master <= hwdata[TC_CLOCK_SOURCE_MASTER];
         tx9 <= hwdata[TC_TX9];
         transmit_enable <= hwdata[TC_TRANSMIT_ENABLE];
         syncSel <= hwdata[TC_SYNC];
         sendBreak <= hwdata[TC_BRK];
         highSpeed <= hwdata[TC_HSPD];
         ninth_tx_bit <= hwdata[TC_NINTH_TX_BIT];
      end
   end

   // data line level, two flop synchroniser
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dinMeta <= 1'b0;
         dinSync <= 1'b0;
      end else begin
         dinMeta <= dataIn;
         dinSync <= dinMeta;
      end
   end

   // mode decode
   assign txMode = serial_port_enable && syncSel && clock_source_master && transmit_enable
      && !single_receive_enable && !continuous_receive_enable;
   assign clkMode = serial_port_enable && syncSel && clock_source_master
      && (transmit_enable || single_receive_enable || continuous_receive_enable);
   assign busy = (state != ST_IDLE);
   assign leadTick = (state == ST_LEAD) && halfTick;
   assign trailTick = (state == ST_TRAIL) && halfTick;
   assign charDone = trailTick && (bitsLeft == LEN_ONE);
   assign charLen = tx9 ? LEN_9 : LEN_8;
   // shifter takes a waiting character once the last bit is out
   assign load = txMode && holdFull
      && (!busy || charDone);
   // holding register; a write in the move cycle refills it
   assign wrHold = wrPhase && (phaseAddr == OFF_TX_DATA);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         holdData <= RST_BYTE;
         holdFull <= 1'b0;
      end else if (!serial_port_enable) begin
         holdFull <= 1'b0;
      end else if (wrHold) begin
         holdData <= hwdata[BYTE_W-1:0];
         holdFull <= 1'b1;
      end else if (load) begin
         holdFull <= 1'b0;
      end
   end

   ssmt_baud_gen u_baud (
      .clk(clk),
      .rstn(rstn),
      .restart(load || !txMode),
      .wide(wide),
      .divLo(divLo),
      .divHi(divHi),
      .halfTick(halfTick)
   );

   // shift sequencer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
      end else if (!txMode) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (load) begin
                  state <= ST_LEAD;
               end
            end
            ST_LEAD: begin
               if (halfTick) begin
                  state <= ST_TRAIL;
               end
            end
            ST_TRAIL: begin
               if (charDone && !load) begin
                  state <= ST_IDLE;
               end else if (halfTick) begin
                  state <= ST_LEAD;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // hidden shift register, data bits only, lsb first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shiftReg <= RST_CHAR;
         bitsLeft <= LEN_ZERO;
      end else if (!txMode) begin
         bitsLeft <= LEN_ZERO;
      end else if (load) begin
         shiftReg <= {ninth_tx_bit, holdData};
         bitsLeft <= charLen;
      end else if (trailTick) begin
         shiftReg <= {1'b0, shiftReg[CHAR_W-1:1]};
         bitsLeft <= bitsLeft - LEN_ONE;
      end
   end

   // clock pin active between a leading and a trailing tick
   assign nextActive = txMode && (leadTick
      || ((state == ST_TRAIL) && !halfTick));
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clkPinOut <= 1'b0;
         dataOut <= 1'b0;
         dataOe <= 1'b0;
         clkPinOe <= 1'b0;
      end else begin
         clkPinOut <= pol ^ nextActive;
         if (leadTick) begin
            dataOut <= shiftReg[0];
         end
         dataOe <= txMode;
         clkPinOe <= clkMode;
      end
   end

   // leading edges counted per character for checking
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         leadCount <= LEN_ZERO;
         loadLen <= LEN_ZERO;
      end else if (load) begin
         leadCount <= LEN_ZERO;
         loadLen <= charLen;
      end else if (leadTick) begin
         leadCount <= leadCount + LEN_ONE;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         leadWait <= {1'b0, BAUD_CNT_RST};
      end else if (state != ST_LEAD || halfTick) begin
         leadWait <= {1'b0, BAUD_CNT_RST};
      end else begin
         leadWait <= leadWait + {1'b0, BAUD_CNT_ONE};
      end
   end
   a_idle_clock: assert property (
      (state == ST_IDLE && $past(state == ST_IDLE) && $stable(pol))
      |-> clkPinOut == pol)
      else $error("clock pin not at idle level");
   a_data_leading: assert property (
      ($changed(dataOut) && $stable(pol))
      |-> (clkPinOut != pol) && $changed(clkPinOut))
      else $error("data changed off a leading edge");
   a_clock_per_bit: assert property (
      charDone |-> leadCount == loadLen)
      else $error("clock count differs from character length");
   a_rx_no_drive: assert property (
      (single_receive_enable || continuous_receive_enable) |=> !dataOe)
      else $error("data driven while receive enabled");
   a_clk_drive: assert property (
      (serial_port_enable && syncSel && clock_source_master && (single_receive_enable || transmit_enable)) |=> clkPinOe)
      else $error("clock driver off in sync master");
   a_tx_drivers: assert property (
      txMode |=> dataOe && clkPinOe)
      else $error("transmit drivers not enabled");
   a_abort_idle: assert property (
      !serial_port_enable |=> !busy && clkPinOut == $past(pol) && !holdFull)
      else $error("disable did not abort transfer");
   a_hold_wait: assert property (
      (holdFull && busy && !charDone && serial_port_enable) |=> holdFull)
      else $error("holding data moved while shifter busy");
   a_move_start: assert property (
      (txMode && holdFull && !busy) |=> state == ST_LEAD)
      else $error("character not started after move");
   a_lead_bound: assert property (
      leadWait <= {1'b1, BAUD_CNT_RST})
      else $error("leading edge late after move");
   a_empty_flag: assert property (
      (load && !wrHold && serial_port_enable) |=> !holdFull)
      else $error("buffer empty flag not set on move");
   a_unimpl_zero: assert property (
      rdPhase |=> hreadyout && hrdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   c_nine_bit: cover property (charDone && loadLen == LEN_9);
   c_back_to_back: cover property (load && state == ST_TRAIL);
   c_abort: cover property (busy && !serial_port_enable);
   c_read: cover property (rdPhase ##1 hreadyout);
endmodule : ssmt_top
`default_nettype wire

// ===== pkg/ssmt_pkg.sv
// offsets, field positions, reset values and states of the serial master
package ssmt_pkg;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int CHAR_W = 9;
   localparam int LEN_W = 4;
   localparam int BAUD_W = 17;
   localparam logic [31:0] OFF_BAUD_CTL = 32'h0000_0000;
   localparam logic [31:0] OFF_RX_CTL = 32'h0000_0004;
   localparam logic [31:0] OFF_DIV_LO = 32'h0000_0008;
   localparam logic [31:0] OFF_DIV_HI = 32'h0000_000C;
   localparam logic [31:0] OFF_TX_DATA = 32'h0000_0010;
   localparam logic [31:0] OFF_TX_CTL = 32'h0000_0014;
   localparam logic [31:0] OFF_LINE_STAT = 32'h0000_0018;
   // baud_control fields
   localparam int BC_POL = 4;
   localparam int BC_WIDE = 3;
   // receive_status_control fields
   localparam int RC_SERIAL_PORT_ENABLE = 7;
   localparam int RC_RX9 = 6;
   localparam int RC_SINGLE_RECEIVE_ENABLE = 5;
   localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
   localparam int RC_ADDEN = 3;
   // transmit_status_control fields
   localparam int TC_CLOCK_SOURCE_MASTER = 7;
   localparam int TC_TX9 = 6;
   localparam int TC_TRANSMIT_ENABLE = 5;
   localparam int TC_SYNC = 4;
   localparam int TC_BRK = 3;
   localparam int TC_HSPD = 2;
   localparam int TC_SHIFT_REGISTER_EMPTY = 1;
   localparam int TC_NINTH_TX_BIT = 0;
   // line status fields
   localparam int LS_TXEMPTY = 0;
   localparam int LS_DLINE = 1;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [8:0] RST_CHAR = 9'h000;
   localparam logic [3:0] LEN_ZERO = 4'h0;
   localparam logic [3:0] LEN_ONE = 4'h1;
   localparam logic [3:0] LEN_8 = 4'h8;
   localparam logic [3:0] LEN_9 = 4'h9;
   localparam logic [16:0] BAUD_CNT_RST = 17'h0_0000;
   localparam logic [16:0] BAUD_CNT_ONE = 17'h0_0001;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LEAD = 3'b010,
      ST_TRAIL = 3'b100
   } ssmt_state_t;
endpackage : ssmt_pkg

// ===== rtl/ssmt_baud_gen.sv
// half bit period tick generator for the shift clock
`timescale 1ns/1ps
`default_nettype none
module ssmt_baud_gen (
   input wire logic clk,
   input wire logic rstn,
   input wire logic restart,
   input wire logic wide,
   input wire logic [ssmt_pkg::BYTE_W-1:0] divLo,
   input wire logic [ssmt_pkg::BYTE_W-1:0] divHi,
   output logic halfTick
);
   import ssmt_pkg::*;
   logic [BAUD_W-1:0] cnt;
   logic [BAUD_W-1:0] limit;
   logic [15:0] divisor;

   // bit period is four times divisor plus one, so half is 2n+2 clocks, counting 0 to 2n+1
   assign divisor = wide ? {divHi, divLo} : {RST_BYTE, divLo};
   assign limit = {divisor, 1'b1};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= BAUD_CNT_RST;
         halfTick <= 1'b0;
      end else if (restart) begin
         cnt <= BAUD_CNT_RST;
         halfTick <= 1'b0;
      end else if (cnt == limit) begin
         cnt <= BAUD_CNT_RST;
         halfTick <= 1'b1;
      end else begin
         cnt <= cnt + BAUD_CNT_ONE;
         halfTick <= 1'b0;
      end
   end
endmodule : ssmt_baud_gen
`default_nettype wire

// ===== test/ssmt_slave_model.sv
// behavioural synchronous slave receiver on the clock and data pins
`timescale 1ns/1ps
`default_nettype none
module ssmt_slave_model (
   input wire logic clkPin,
   input wire logic dataPin,
   input wire logic pol,
   input wire logic clear,
   output var int leadCount,
   output var int bitCount,
   output var int glitches,
   output var int periodNs,
   output var logic [17:0] rxBits
);
   logic capVal;
   realtime lastLead;
   // listens only, never drives the data line
   always @(posedge clear) begin
      leadCount = 0;
      bitCount = 0;
      glitches = 0;
      rxBits = '0;
      capVal = 1'b0;
   end
   // shifts only on edges of the master clock
   always @(clkPin) begin
      if (clkPin !== pol) begin
         leadCount++;
         periodNs = int'($realtime - lastLead);
         lastLead = $realtime;
         #1 capVal = dataPin;
      end else begin
         if (dataPin !== capVal) begin
            glitches++;
         end
         if (bitCount < 18) begin
            rxBits[bitCount] = dataPin;
         end
         bitCount++;
      end
   end
endmodule : ssmt_slave_model
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the synchronous serial master transmitter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ssmt_pkg::*;
   logic clk, rstn, hsel, hwrite, dataOut, dataOe, clkPinOut, clkPinOe;
   logic hreadyout, hresp, dataWire, lastLvl, pol, clear;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [17:0] rxBits;
   int errors, check_count, leadCount, bitCount, glitches, periodNs;
   logic [7:0] modeRx [0:5] = '{8'h80, 8'h80, 8'h80, 8'hA0, 8'h90, 8'h00};
   logic [7:0] modeTx [0:5] = '{8'hB0, 8'hA0, 8'h30, 8'hB0, 8'h90, 8'hB0};
   logic [1:0] modeOe [0:5] = '{2'h3, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0};
   // released data line shows a changing pattern
   always @(posedge clk) lastLvl <= dataWire;
   assign dataWire = dataOe ? dataOut : ~lastLvl;
   ssmt_top uut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .dataIn(dataWire), .dataOut(dataOut), .dataOe(dataOe),
      .clkPinOut(clkPinOut), .clkPinOe(clkPinOe));
   ssmt_slave_model partner (.clkPin(clkPinOut), .dataPin(dataWire),
      .pol(pol), .clear(clear), .leadCount(leadCount), .bitCount(bitCount),
      .glitches(glitches), .periodNs(periodNs), .rxBits(rxBits));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic waitReady();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (k >= 20) begin
         errors++;
         complete_run();
      end
   endtask : waitReady
   // one ahb-lite single transfer, read data left in rd
   task automatic bus(input logic wr, input logic [31:0] a,
         input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= a;
      waitReady();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      waitReady();
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rdc
   task automatic waitIdle();
      int k;
      k = 0;
      do begin
         bus(1'b0, OFF_TX_CTL, 32'h0000_0000);
         k++;
      end while (rd[TC_SHIFT_REGISTER_EMPTY] !== 1'b1 && k < 400);
      if (k >= 400) begin
         errors++;
         complete_run();
      end
      repeat (40) @(posedge clk);
   endtask : waitIdle
   task automatic clearPartner();
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
   endtask : clearPartner
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      lastLvl = 1'b0;
      pol = 1'b0;
      clear = 1'b0;
      errors = 0;
      check_count = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      // reset values, masks, unmapped and hidden places
      rdc(OFF_BAUD_CTL, 32'h0000_0000);
      rdc(OFF_RX_CTL, 32'h0000_0000);
      rdc(OFF_DIV_LO, 32'h0000_0000);
      rdc(OFF_TX_CTL, 32'h0000_0002);
      bus(1'b0, OFF_LINE_STAT, 32'h0000_0000);
      chk(rd[LS_TXEMPTY], 1'b1);
      wr(OFF_DIV_HI, 32'hFFFF_FFFF);
      rdc(OFF_DIV_HI, 32'h0000_00FF);
      wr(OFF_BAUD_CTL, 32'hFFFF_FFFF);
      rdc(OFF_BAUD_CTL, 32'h0000_0018);
      wr(OFF_RX_CTL, 32'hFFFF_FFFF);
      rdc(OFF_RX_CTL, 32'h0000_00F8);
      wr(32'h0000_0040, 32'hFFFF_FFFF);
      rdc(32'h0000_0040, 32'h0000_0000);
      chk(hresp, 1'b0);
      rdc(OFF_TX_DATA, 32'h0000_0000);
      $display("test registers done");
      // pin drivers for six mode combinations
      wr(OFF_BAUD_CTL, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         wr(OFF_RX_CTL, {24'h00_0000, modeRx[i]});
         wr(OFF_TX_CTL, {24'h00_0000, modeTx[i]});
         repeat (2) @(posedge clk);
         chk({clkPinOe, dataOe}, modeOe[i]);
      end
      chk(clkPinOut, 1'b0);
      $display("test modes done");
      // two back-to-back characters, idle low clock
      wr(OFF_DIV_HI, 32'h0000_0001);
      wr(OFF_DIV_LO, 32'h0000_0001);
      wr(OFF_TX_CTL, 32'h0000_0090);
      wr(OFF_RX_CTL, 32'h0000_0080);
      wr(OFF_TX_CTL, 32'h0000_00B0);
      clearPartner();
      wr(OFF_TX_DATA, 32'h0000_00A5);
      wr(OFF_TX_DATA, 32'h0000_003C);
      bus(1'b0, OFF_TX_CTL, 32'h0000_0000);
      chk(rd[TC_SHIFT_REGISTER_EMPTY], 1'b0);
      bus(1'b0, OFF_LINE_STAT, 32'h0000_0000);
      chk(rd[LS_TXEMPTY], 1'b0);
      waitIdle();
      chk(leadCount, 16);
      chk(rxBits[15:0], 16'h3CA5);
      chk(glitches, 0);
      chk(periodNs, 200);
      chk(clkPinOut, 1'b0);
      bus(1'b0, OFF_LINE_STAT, 32'h0000_0000);
      chk(rd[LS_TXEMPTY], 1'b1);
      chk(rd[LS_DLINE], 1'b0);
      $display("test transmit done");
      // nine-bit character with idle high clock
      pol = 1'b1;
      wr(OFF_DIV_HI, 32'h0000_0000);
      wr(OFF_BAUD_CTL, 32'h0000_0018);
      repeat (2) @(posedge clk);
      chk(clkPinOut, 1'b1);
      clearPartner();
      wr(OFF_TX_CTL, 32'h0000_00F1);
      wr(OFF_TX_DATA, 32'h0000_005A);
      waitIdle();
      chk(leadCount, 9);
      chk(rxBits[8:0], 9'h15A);
      chk(glitches, 0);
      chk(periodNs, 200);
      $display("test nine bit done");
      // abort mid-character, then writes while disabled
      wr(OFF_DIV_LO, 32'h0000_0007);
      wr(OFF_TX_DATA, 32'h0000_00FF);
      repeat (60) @(posedge clk);
      wr(OFF_RX_CTL, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk({clkPinOut, clkPinOe, dataOe}, 3'b100);
      rdc(OFF_TX_CTL, 32'h0000_00F3);
      wr(OFF_TX_DATA, 32'h0000_0055);
      clearPartner();
      wr(OFF_RX_CTL, 32'h0000_0080);
      repeat (100) @(posedge clk);
      chk(leadCount, 0);
      $display("test abort done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
